// ==== dv/drive_model.sv ====
// Behavioural drive: answers execution, drains sector data
`timescale 1ns/10ps
module drive_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Execution link
	input wire logic start_i,
	input wire logic hold_i,
	output logic done_o = 1'b0,
	output logic [7:0] res_o [0:6],
	// Sector data
	input wire logic valid_i,
	input wire logic [7:0] data_i,
	output logic ready_o = 1'b0
);
	logic [31:0] s = 32'h0000c0de;
	logic busy = 1'b0;
	int wait_n = 0;
	int stall_n = 0;
	logic [7:0] snap [0:6];
	logic [7:0] got [$];
	always @(posedge clk_i) begin
		s <= {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		done_o <= 1'b0;
		// Junk outside the done cycle
		for (int i = 0; i < 7; i++)
			res_o[i] <= s[7:0] ^ 8'(i);
		if (rst_i)
			busy <= 1'b0;
		else if (start_i) begin
			busy <= 1'b1;
			wait_n <= 3 + int'(s[3:0]);
			stall_n <= 100;
		end else if (busy && !hold_i && wait_n == 0) begin
			busy <= 1'b0;
			done_o <= 1'b1;
			for (int i = 0; i < 7; i++) begin
				snap[i] <= s[i +: 8];
				res_o[i] <= s[i +: 8];
			end
		end else if (wait_n > 0)
			wait_n <= wait_n - 1;
		if (stall_n > 0)
			stall_n <= stall_n - 1;
		// Long stall first so the buffer fills
		ready_o <= stall_n == 0 && s[5];
		if (valid_i && ready_o)
			got.push_back(data_i);
	end
endmodule : drive_model

// ==== dv/floppy_cmd_id_verify_write_asserts.sv ====
// Bus, execution and sector stream checks for the command sequencer
`timescale 1ns/10ps
module floppy_cmd_asserts (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Drive side
	input wire logic exec_start_o,
	input wire floppy_cmd_pkg::cmd_t exec_cmd_o,
	input wire logic disk_data_valid_o,
	input wire logic [7:0] disk_data_o,
	input wire logic disk_data_ready_i
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Data writes may stall on a full buffer
	sequence s_req;
		cyc_i && stb_i && !ack_o && !(we_i && adr_i == 4'h0);
	endsequence
	sequence s_stall;
		disk_data_valid_o && !disk_data_ready_i;
	endsequence
	ack_answer_a: assert property (s_req |-> ##[1:2] ack_o)
		else $error("request not answered");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	read_unmapped_a: assert property (ack_o && !we_i && adr_i != 4'h0 &&
		adr_i != 4'h4 |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
	read_upper_a: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	start_cause_a: assert property (exec_start_o |->
		$past(ack_o && we_i) || $past(ack_o && we_i, 2))
		else $error("start without parameter write");
	start_quiet_a: assert property (exec_start_o |=> !exec_start_o [*8])
		else $error("start repeated");
	version_quiet_a: assert property (
		exec_cmd_o == floppy_cmd_pkg::CMD_VERSION |-> !exec_start_o)
		else $error("version started execution");
	stream_hold_a: assert property (s_stall |=>
		disk_data_valid_o && $stable(disk_data_o))
		else $error("sector byte changed while stalled");
endmodule : floppy_cmd_asserts
bind floppy_cmd_id_verify_write floppy_cmd_asserts u_chk (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.dat_o(dat_o), .ack_o(ack_o), .exec_start_o(exec_start_o),
	.exec_cmd_o(exec_cmd_o), .disk_data_valid_o(disk_data_valid_o),
	.disk_data_o(disk_data_o), .disk_data_ready_i(disk_data_ready_i));

// ==== dv/tb_floppy_cmd_id_verify_write.sv ====
// Self-checking bench for the command sequencer
`timescale 1ns/10ps
`include "floppy_cmd_regs.svh"
module tb_floppy_cmd_id_verify_write;
	// Arbitrary identity value
	localparam logic [7:0] VID = 8'h3c;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, hold = 0;
	logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rd, seed = 34701;
	logic ack_o, exec_start_o, exec_done_i, disk_data_valid_o;
	logic disk_data_ready_i, multi_track_flag_o, double_density_flag_o;
	logic skip_deleted_flag_o, enable_count_flag_o, head_select_o;
	logic drive_select_hi_o, drive_select_lo_o;
	logic [7:0] disk_data_o, pr [0:6], rs [0:6], d [0:39];
	logic [4:0] lo [0:3] = '{`OP_READ_ID, `OP_VERIFY, `OP_WRITE, `OP_WRITE_DEL};
	floppy_cmd_pkg::cmd_t exec_cmd_o;
	int fails = 0, samples_checked = 0, cycles = 0;
	floppy_cmd_id_verify_write #(.VERSION_ID(VID)) dut (.clk_i, .rst_i,
		.cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.exec_start_o, .exec_cmd_o, .multi_track_flag_o, .double_density_flag_o,
		.skip_deleted_flag_o, .enable_count_flag_o, .head_select_o,
		.drive_select_hi_o, .drive_select_lo_o, .cylinder_o(pr[0]),
		.head_o(pr[1]), .sector_o(pr[2]), .size_code_o(pr[3]),
		.final_sector_number_o(pr[4]), .gap_length_o(pr[5]),
		.data_length_o(pr[6]), .exec_done_i, .status_byte_zero_i(rs[0]),
		.status_byte_one_i(rs[1]), .status_byte_two_i(rs[2]),
		.id_cylinder_i(rs[3]), .id_head_i(rs[4]), .id_sector_i(rs[5]),
		.id_size_code_i(rs[6]), .disk_data_valid_o, .disk_data_o,
		.disk_data_ready_i);
	drive_model u_drive (.clk_i, .rst_i, .start_i(exec_start_o),
		.hold_i(hold), .done_o(exec_done_i), .res_o(rs),
		.valid_i(disk_data_valid_o), .data_i(disk_data_o),
		.ready_o(disk_data_ready_i));
	always #2 clk_i = ~clk_i;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Status byte as the phase should show it
	function automatic logic [31:0] stat_exp(input logic q, input logic h,
		input logic x, input logic b);
		stat_exp = 32'h0000_0000;
		stat_exp[`STAT_REQUEST_BIT] = q;
		stat_exp[`STAT_TO_HOST_BIT] = h;
		stat_exp[`STAT_EXEC_BIT] = x;
		stat_exp[`STAT_BUSY_BIT] = b;
	endfunction : stat_exp
	task automatic finish_test();
		if (fails == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			$display("[ERR] %0t got %h expected %h", $time, g, e);
			fails++;
		end
	endtask : chk
	// Entered just after an edge; holds until ack is sampled
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] b);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'h1;
		dat_i <= {24'h0, b};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		@(posedge clk_i);
	endtask : wb
	task automatic run(input int k);
		logic [7:0] p [0:7];
		logic [2:0] f;
		f = 3'(rnd()) & (k == 0 ? 3'b010 : k == 1 ? 3'b111 : 3'b110);
		for (int i = 0; i < 8; i++)
			p[i] = 8'(rnd());
		p[0] = {k == 1 && p[0][7], 4'h0, p[0][2:0]};
		hold <= k > 1;
		wb(1, 4'h0, {f, lo[k]});
		for (int i = 0; i < (k == 0 ? 1 : 8); i++)
			wb(1, 4'h0, p[i]);
		chk(exec_cmd_o, k + 1);
		chk(double_density_flag_o, f[1]);
		chk(multi_track_flag_o, f[2]);
		chk(skip_deleted_flag_o, f[0]);
		chk(enable_count_flag_o, p[0][7]);
		chk({head_select_o, drive_select_hi_o, drive_select_lo_o}, p[0][2:0]);
		for (int i = 0; i < 7 && k > 0; i++)
			chk(pr[i], p[i + 1]);
		if (k > 1) begin
			wb(0, 4'h4, 8'h0);
			chk(rd, stat_exp(1'b1, 1'b0, 1'b1, 1'b1));
			for (int i = 0; i < 40; i++) begin
				d[i] = 8'(rnd());
				wb(1, 4'h0, d[i]);
			end
			while (u_drive.got.size() < 40)
				@(posedge clk_i);
			for (int i = 0; i < 40; i++)
				chk(u_drive.got[i], d[i]);
			u_drive.got.delete();
			hold <= 0;
		end
		rd = 0;
		while (rd[`STAT_TO_HOST_BIT] !== 1'b1)
			wb(0, 4'h4, 8'h0);
		for (int i = 0; i < 7; i++) begin
			wb(0, 4'h0, 8'h0);
			chk(rd, {24'h0, u_drive.snap[i]});
		end
		wb(0, 4'h0, 8'h0);
		chk(rd, 0);
	endtask : run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk(dat_o, 0);
		chk({ack_o, exec_start_o, disk_data_valid_o, exec_cmd_o}, 0);
		wb(1, 4'h0, `OP_VERSION);
		wb(0, 4'h4, 8'h0);
		chk(rd, stat_exp(1'b1, 1'b1, 1'b0, 1'b1));
		wb(0, 4'h0, 8'h0);
		chk(rd, {24'h0, VID});
		wb(1, 4'h0, 8'h00);
		wb(0, 4'h0, 8'h0);
		chk(rd, {24'h0, `INVALID_STATUS});
		wb(0, 4'h4, 8'h0);
		chk(rd, stat_exp(1'b1, 1'b0, 1'b0, 1'b0));
		wb(0, 4'h8, 8'h0);
		chk(rd, 0);
		for (int k = 0; k < 12; k++)
			run(k % 4);
		finish_test();
	end
endmodule : tb_floppy_cmd_id_verify_write

// ==== verilog/byte_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`include "floppy_cmd_regs.svh"
module byte_fifo #(
	parameter int WIDTH = `FIFO_WIDTH,
	parameter int DEPTH = `FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Filling side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Draining side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [CW-1:0] cnt;
	} fifo_state_t;

	fifo_state_t s_reg;
	fifo_state_t s_next;
	logic push;
	logic pop;

	assign in_ready_o = s_reg.cnt != CW'(DEPTH);
	assign out_valid_o = s_reg.cnt != '0;
	assign out_data_o = s_reg.mem[s_reg.rd];

	always_comb begin
		s_next = s_reg;
		push = in_valid_i & in_ready_o;
		pop = out_valid_o & out_ready_i;
		if (push) begin
			s_next.mem[s_reg.wr] = in_data_i;
			s_next.wr = (s_reg.wr == AW'(DEPTH - 1)) ? '0 : s_reg.wr + AW'(1);
		end
		if (pop) begin
			s_next.rd = (s_reg.rd == AW'(DEPTH - 1)) ? '0 : s_reg.rd + AW'(1);
		end
		case ({push, pop})
			2'b10: s_next.cnt = s_reg.cnt + CW'(1);
			2'b01: s_next.cnt = s_reg.cnt - CW'(1);
			default: s_next.cnt = s_reg.cnt;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule : byte_fifo

// ==== verilog/floppy_cmd_id_verify_write.sv ====
// Command, execution and result sequencer for five disk commands
//
// Notes on behaviour
// [R1] Read id: opcode, drive byte, capture id
// [R2] Read id answers three status, then C/H/R/N
// [R3] Verify flags multi-track, density, skip, count
// [R4] Write commands: flags, host data to drive
// [R5] Host sends drive byte then seven parameters
// [R6] Verify/write answer status then final C/H/R/N
// [R7] First three answers are status registers
// [R8] Version: one byte answer, no execution
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`include "floppy_cmd_regs.svh"
module floppy_cmd_id_verify_write (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Execution request to the drive side
	output logic exec_start_o,
	output floppy_cmd_pkg::cmd_t exec_cmd_o,
	output logic multi_track_flag_o,
	output logic double_density_flag_o,
	output logic skip_deleted_flag_o,
	output logic enable_count_flag_o,
	output logic head_select_o,
	output logic drive_select_hi_o,
	output logic drive_select_lo_o,
	output logic [7:0] cylinder_o,
	output logic [7:0] head_o,
	output logic [7:0] sector_o,
	output logic [7:0] size_code_o,
	output logic [7:0] final_sector_number_o,
	output logic [7:0] gap_length_o,
	output logic [7:0] data_length_o,
	// Execution outcome from the drive side
	input wire logic exec_done_i,
	input wire logic [7:0] status_byte_zero_i,
	input wire logic [7:0] status_byte_one_i,
	input wire logic [7:0] status_byte_two_i,
	input wire logic [7:0] id_cylinder_i,
	input wire logic [7:0] id_head_i,
	input wire logic [7:0] id_sector_i,
	input wire logic [7:0] id_size_code_i,
	// Sector data toward the disk drive
	output logic disk_data_valid_o,
	output logic [7:0] disk_data_o,
	input wire logic disk_data_ready_i
);
	parameter logic [7:0] VERSION_ID = `VERSION_ID_DEFAULT;

	floppy_cmd_pkg::ctl_state_t s_reg;
	floppy_cmd_pkg::ctl_state_t s_next;
	logic fifo_ready;
	logic fifo_push;
	logic hit;
	logic commit;
	logic data_sel;
	logic data_wr;
	logic stall;
	logic to_fifo;
	logic [7:0] status_val;

	function automatic floppy_cmd_pkg::cmd_t decode_cmd(input logic [7:0] b);
		if (b == `OP_VERSION)
			decode_cmd = floppy_cmd_pkg::CMD_VERSION; // R8
		else if (b[4:0] == `OP_READ_ID && !b[7] && !b[5])
			decode_cmd = floppy_cmd_pkg::CMD_READ_ID; // R1
		else if (b[4:0] == `OP_VERIFY)
			decode_cmd = floppy_cmd_pkg::CMD_VERIFY; // R3
		else if (b[4:0] == `OP_WRITE && !b[5])
			decode_cmd = floppy_cmd_pkg::CMD_WRITE; // R4
		else if (b[4:0] == `OP_WRITE_DEL && !b[5])
			decode_cmd = floppy_cmd_pkg::CMD_WRITE_DEL; // R4
		else
			decode_cmd = floppy_cmd_pkg::CMD_INVALID;
	endfunction : decode_cmd

	function automatic logic [3:0] param_count(
		input floppy_cmd_pkg::cmd_t c);
		case (c)
			floppy_cmd_pkg::CMD_READ_ID: param_count = `PARAMS_READ_ID;
			floppy_cmd_pkg::CMD_VERIFY,
			floppy_cmd_pkg::CMD_WRITE,
			floppy_cmd_pkg::CMD_WRITE_DEL: param_count = `PARAMS_FULL; // R5
			default: param_count = 4'h0;
		endcase
	endfunction : param_count

	function automatic logic is_write(input floppy_cmd_pkg::cmd_t c);
		is_write = c == floppy_cmd_pkg::CMD_WRITE ||
			c == floppy_cmd_pkg::CMD_WRITE_DEL;
	endfunction : is_write

	// Sector data path; a full buffer holds off the host's ack
	byte_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(fifo_push),
		.in_data_i(dat_i[7:0]),
		.in_ready_o(fifo_ready),
		.out_valid_o(disk_data_valid_o),
		.out_data_o(disk_data_o),
		.out_ready_i(disk_data_ready_i)
	);

	assign to_fifo = s_reg.phase == floppy_cmd_pkg::PH_EXEC &&
		is_write(s_reg.cmd);
	assign data_sel = adr_i == `DATA_REG_OFS;
	assign hit = cyc_i & stb_i & ~s_reg.ack;
	assign commit = cyc_i & stb_i & s_reg.ack;
	assign data_wr = commit & we_i & data_sel & sel_i[0];
	assign stall = we_i & data_sel & sel_i[0] & to_fifo & ~fifo_ready;
	assign fifo_push = data_wr & to_fifo; // R4

	always_comb begin
		status_val = 8'h00;
		status_val[`STAT_REQUEST_BIT] =
			s_reg.phase != floppy_cmd_pkg::PH_EXEC ||
			(is_write(s_reg.cmd) && fifo_ready);
		status_val[`STAT_TO_HOST_BIT] =
			s_reg.phase == floppy_cmd_pkg::PH_RESULT;
		status_val[`STAT_EXEC_BIT] = s_reg.phase == floppy_cmd_pkg::PH_EXEC;
		status_val[`STAT_BUSY_BIT] = s_reg.phase != floppy_cmd_pkg::PH_IDLE;
	end

	always_comb begin
		s_next = s_reg;
		s_next.start = 1'b0;
		s_next.ack = 1'b0;
		if (hit && !stall) begin
			s_next.ack = 1'b1;
			s_next.dat = 32'h0000_0000;
			if (!we_i && data_sel &&
				s_reg.phase == floppy_cmd_pkg::PH_RESULT)
				s_next.dat[7:0] = s_reg.res[s_reg.idx[2:0]];
			else if (!we_i && adr_i == `STATUS_REG_OFS)
				s_next.dat[7:0] = status_val;
		end
		case (s_reg.phase)
			floppy_cmd_pkg::PH_IDLE: begin
				if (data_wr) begin
					s_next.cmd = decode_cmd(dat_i[7:0]);
					s_next.opcode = dat_i[7:0];
					s_next.idx = 4'h0;
					if (param_count(s_next.cmd) == 4'h0) begin
						// Version and unknown opcodes skip execution
						s_next.res_cnt = 3'h1;
						s_next.res[0] =
							(s_next.cmd == floppy_cmd_pkg::CMD_VERSION) ?
							VERSION_ID : `INVALID_STATUS; // R8
						s_next.phase = floppy_cmd_pkg::PH_RESULT;
					end else begin
						s_next.phase = floppy_cmd_pkg::PH_PARAM;
					end
				end
			end
			floppy_cmd_pkg::PH_PARAM: begin
				if (data_wr) begin
					s_next.prm[s_reg.idx[2:0]] = dat_i[7:0]; // R5
					s_next.idx = s_reg.idx + 4'h1;
					if (s_reg.idx + 4'h1 == param_count(s_reg.cmd)) begin
						s_next.phase = floppy_cmd_pkg::PH_EXEC;
						s_next.start = 1'b1; // R1
					end
				end
			end
			floppy_cmd_pkg::PH_EXEC: begin
				if (exec_done_i) begin
					s_next.res[0] = status_byte_zero_i; // R7
					s_next.res[1] = status_byte_one_i; // R7
					s_next.res[2] = status_byte_two_i; // R7
					s_next.res[3] = id_cylinder_i; // R2 R6
					s_next.res[4] = id_head_i; // R2 R6
					s_next.res[5] = id_sector_i; // R2 R6
					s_next.res[6] = id_size_code_i; // R2 R6
					s_next.res_cnt = `RESULT_BYTES;
					s_next.idx = 4'h0;
					s_next.phase = floppy_cmd_pkg::PH_RESULT;
				end
			end
			floppy_cmd_pkg::PH_RESULT: begin
				if (commit && !we_i && data_sel) begin
					s_next.idx = s_reg.idx + 4'h1;
					if (s_reg.idx[2:0] + 3'h1 == s_reg.res_cnt)
						s_next.phase = floppy_cmd_pkg::PH_IDLE;
				end
			end
			default: s_next.phase = floppy_cmd_pkg::PH_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign ack_o = s_reg.ack;
	assign dat_o = s_reg.dat;
	assign exec_start_o = s_reg.start;
	assign exec_cmd_o = s_reg.cmd;
	// Flags only exist where the command defines them, except double density, which follows the opcode bit for any command
	assign multi_track_flag_o = s_reg.opcode[`MULTI_TRACK_BIT] &
		(s_reg.cmd == floppy_cmd_pkg::CMD_VERIFY ||
		is_write(s_reg.cmd)); // R3 R4
	assign double_density_flag_o = s_reg.opcode[`DENSITY_BIT]; // R1 R3 R4
	assign skip_deleted_flag_o = s_reg.opcode[`SKIP_BIT] &
		(s_reg.cmd == floppy_cmd_pkg::CMD_VERIFY); // R3
	assign enable_count_flag_o = s_reg.prm[0][`ENABLE_COUNT_BIT] &
		(s_reg.cmd == floppy_cmd_pkg::CMD_VERIFY); // R3
	assign head_select_o = s_reg.prm[0][`HEAD_SELECT_BIT]; // R5
	assign drive_select_hi_o = s_reg.prm[0][1];
	assign drive_select_lo_o = s_reg.prm[0][0];
	assign cylinder_o = s_reg.prm[1];
	assign head_o = s_reg.prm[2];
	assign sector_o = s_reg.prm[3];
	assign size_code_o = s_reg.prm[4];
	assign final_sector_number_o = s_reg.prm[5];
	assign gap_length_o = s_reg.prm[6];
	assign data_length_o = s_reg.prm[7];
endmodule : floppy_cmd_id_verify_write

// ==== verilog/floppy_cmd_pkg.sv ====
// Types shared by the command decoder, its checks and its bench
package floppy_cmd_pkg;

	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_PARAM = 2'h1,
		PH_EXEC = 2'h3,
		PH_RESULT = 2'h2
	} phase_t;

	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_READ_ID = 3'h1,
		CMD_VERIFY = 3'h2,
		CMD_WRITE = 3'h3,
		CMD_WRITE_DEL = 3'h4,
		CMD_VERSION = 3'h5,
		CMD_INVALID = 3'h6
	} cmd_t;

	typedef struct packed {
		phase_t phase;
		cmd_t cmd;
		logic [7:0] opcode;
		logic [3:0] idx;
		logic [7:0][7:0] prm;
		logic [6:0][7:0] res;
		logic [2:0] res_cnt;
		logic ack;
		logic [31:0] dat;
		logic start;
	} ctl_state_t;

endpackage : floppy_cmd_pkg

// ==== verilog/floppy_cmd_regs.svh ====
// Offsets, field positions, default and answer values and counts of the command decoder
`ifndef FLOPPY_CMD_REGS_SVH
`define FLOPPY_CMD_REGS_SVH

// Wishbone byte offsets
`define DATA_REG_OFS 4'h0
`define STATUS_REG_OFS 4'h4

// Status register bit positions
`define STAT_REQUEST_BIT 7
`define STAT_TO_HOST_BIT 6
`define STAT_EXEC_BIT 5
`define STAT_BUSY_BIT 4

// Opcode encodings (low five bits, except the full-byte version opcode)
`define OP_VERSION 8'h10
`define OP_READ_ID 5'h0a
`define OP_VERIFY 5'h16
`define OP_WRITE 5'h05
`define OP_WRITE_DEL 5'h09

// Flag positions in opcode and drive-select byte
`define MULTI_TRACK_BIT 7
`define DENSITY_BIT 6
`define SKIP_BIT 5
`define ENABLE_COUNT_BIT 7
`define HEAD_SELECT_BIT 2

// Byte counts
`define PARAMS_FULL 4'h8
`define PARAMS_READ_ID 4'h1
`define RESULT_BYTES 3'h7

// Answer bytes; the identity value is arbitrary
`define VERSION_ID_DEFAULT 8'h5a
`define INVALID_STATUS 8'h80

// Sector data buffer
`define FIFO_WIDTH 8
`define FIFO_DEPTH 32

`endif
